/* rtl/sfcar_pkg.sv */
// shared constants and types for the continuous array read sequencer
package sfcar_pkg;

    // ****************************************
    // opcodes of the four continuous reads
    // ****************************************
    localparam logic [7:0] OP_READ_FASTEST = 8'h1b; // two dummy bytes
    localparam logic [7:0] OP_READ_HIGH = 8'h0b; // one dummy byte
    localparam logic [7:0] OP_READ_LOW = 8'h03; // no dummy bytes
    localparam logic [7:0] OP_READ_LOW_POWER = 8'h01; // no dummy bytes

    // ****************************************
    // dummy byte counts per opcode
    // ****************************************
    localparam logic [1:0] DUMMY_FASTEST = 2'h2;
    localparam logic [1:0] DUMMY_HIGH = 2'h1;
    localparam logic [1:0] DUMMY_NONE = 2'h0;
    localparam logic [1:0] DUMMY_ONE = 2'h1; // last dummy byte owed

    // ****************************************
    // serial framing
    // ****************************************
    localparam logic [2:0] BIT_LAST = 3'h7; // last bit index of a byte
    localparam logic [2:0] BIT_FIRST = 3'h0; // first bit index of a byte
    localparam logic [1:0] ADDR_BYTE_LAST = 2'h2; // third address byte
    localparam int ADDR_W = 24; // raw address field width

    // ****************************************
    // array geometry
    // ****************************************
    localparam int PAGE_W = 12; // page_index_bits width
    localparam int OFS_W = 9; // byte_offset_bits width
    localparam logic [8:0] OFS_LAST_264 = 9'h107; // byte 263
    localparam logic [8:0] OFS_LAST_256 = 9'h0ff; // byte 255
    localparam logic [8:0] OFS_ZERO = 9'h000;
    localparam logic [11:0] PAGE_STEP = 12'h001;
    localparam logic [8:0] OFS_STEP = 9'h001;

    // address of one array byte: page and byte within the page
    typedef struct packed {
        logic [PAGE_W-1:0] page_index_bits;
        logic [OFS_W-1:0] byte_offset_bits;
    } sfcar_array_addr_s;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } sfcar_state_e;

endpackage : sfcar_pkg

/* rtl/sfcar_read.sv */
// continuous main array read sequencer behind the serial link
//
// Summary of operation
// - 1Bh: three address, two dummy bytes
// - 0Bh: three address, one dummy byte
// - 03h: three address, data follows directly
// - 01h: three address, data follows directly
// - 264 layout: 12 page, 9 byte bits
// - 256 layout: linear address bits 19..0
// - each further clock shifts next data bit
// - page end continues at next page, no gap
// - array end wraps to page zero
// - select rising aborts, output goes tristate
// - reads never alter the SRAM buffers
// - all fields shifted MSB first
// - 256 layout: page 19..8, byte 7..0
// - internal address counter advances automatically
`timescale 1ns/1ns
module sfcar_read (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic page_256_i,
    input wire logic [7:0] array_data_i,
    output logic so_o,
    output logic so_oe_n_o,
    output sfcar_pkg::sfcar_array_addr_s array_addr_o,
    output logic active_o
);

    // ****************************************
    // functions
    // ****************************************

    // both layouts use the same 21-bit counter; in the 256 layout
    // the top offset bit simply stays zero
    // map the raw 24-bit field onto page and byte
    function automatic sfcar_pkg::sfcar_array_addr_s map_addr(
        input logic [sfcar_pkg::ADDR_W-1:0] raw,
        input logic bin_pages
    );
        sfcar_pkg::sfcar_array_addr_s res;
        if (bin_pages) begin
            // page from 19..8, byte from 7..0
            res.page_index_bits = raw[19:8];
            res.byte_offset_bits = {1'b0, raw[7:0]};
        end else begin
            // 12/9 split, top three bits dropped
            res.page_index_bits = raw[20:9];
            res.byte_offset_bits = raw[8:0];
        end
        return res;
    endfunction : map_addr

    // step to the next array byte
    function automatic sfcar_pkg::sfcar_array_addr_s next_addr(
        input sfcar_pkg::sfcar_array_addr_s cur,
        input logic bin_pages
    );
        sfcar_pkg::sfcar_array_addr_s res;
        logic [8:0] last;
        last = bin_pages ? sfcar_pkg::OFS_LAST_256 : sfcar_pkg::OFS_LAST_264;
        res = cur;
        // an offset past the page end is treated as the last byte,
        // so a stray start address can never stall the stream
        if (cur.byte_offset_bits >= last) begin
            // page end rolls into next page
            res.byte_offset_bits = sfcar_pkg::OFS_ZERO;
            // page counter wraps past the last page
            res.page_index_bits = cur.page_index_bits + sfcar_pkg::PAGE_STEP;
        end else begin
            res.byte_offset_bits = cur.byte_offset_bits + sfcar_pkg::OFS_STEP;
        end
        return res;
    endfunction : next_addr

    // ****************************************
    // pin synchronisers
    // ****************************************

    logic [1:0] cs_sync; // select, two stages
    logic [1:0] sck_sync; // serial clock, two stages
    logic [1:0] si_sync; // serial input, two stages
    logic sck_prev; // last synced clock level, for edges

    // each pin costs two clocks of latency, so the link clock must
    // stay high and low for at least two system clocks to be seen;
    // select resets high so that release finds the link idle
    // two flops per pin, only stage two is read
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cs_sync <= 2'h3;
            sck_sync <= 2'h0;
            si_sync <= 2'h0;
            sck_prev <= 1'b0;
        end else begin
            cs_sync <= {cs_sync[0], cs_n_i};
            sck_sync <= {sck_sync[0], sck_i};
            si_sync <= {si_sync[0], si_i};
            sck_prev <= sck_sync[1];
        end
    end

    logic cs_n_s; // synced select
    logic sck_s; // synced clock
    logic si_s; // synced input
    logic sck_rise; // one-cycle rising edge enable
    logic sck_fall; // one-cycle falling edge enable

    assign cs_n_s = cs_sync[1];
    assign sck_s = sck_sync[1];
    assign si_s = si_sync[1];
    assign sck_rise = sck_s & ~sck_prev;
    assign sck_fall = ~sck_s & sck_prev;

    // ****************************************
    // sequencer state
    // ****************************************
    // the command is taken byte by byte on synced clock rises, while
    // the data phase shifts on synced falls: this serves link modes 0
    // and 3 alike, since falls before the first rise are never used

    sfcar_pkg::sfcar_state_e state; // command phase
    logic [2:0] bit_cnt; // bit within input byte
    logic [7:0] in_sh; // input shift register
    logic [1:0] addr_cnt; // address byte index
    logic [1:0] dummy_left; // dummy bytes still owed
    logic [15:0] addr_sh; // first two address bytes
    sfcar_pkg::sfcar_array_addr_s rd_addr; // read address counter
    logic [7:0] out_sh; // output shift register
    logic [2:0] out_cnt; // bit within output byte
    logic so; // serial output bit
    logic so_oe_n; // output enable, low drives

    sfcar_pkg::sfcar_state_e next_state;
    logic [2:0] next_bit_cnt;
    logic [7:0] next_in_sh;
    logic [1:0] next_addr_cnt;
    logic [1:0] next_dummy_left;
    logic [15:0] next_addr_sh;
    sfcar_pkg::sfcar_array_addr_s next_rd_addr;
    logic [7:0] next_out_sh;
    logic [2:0] next_out_cnt;
    logic next_so;
    logic next_so_oe_n;

    // next values of the whole sequencer
    always_comb begin
        logic [7:0] byte_in;
        logic byte_done;
        byte_in = {in_sh[6:0], si_s};
        byte_done = sck_rise && (bit_cnt == sfcar_pkg::BIT_LAST);
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_in_sh = in_sh;
        next_addr_cnt = addr_cnt;
        next_dummy_left = dummy_left;
        next_addr_sh = addr_sh;
        next_rd_addr = rd_addr;
        next_out_sh = out_sh;
        next_out_cnt = out_cnt;
        next_so = so;
        next_so_oe_n = so_oe_n;
        // input bit capture in every receive phase
        if (sck_rise && (state == sfcar_pkg::ST_OPCODE || state == sfcar_pkg::ST_ADDR
                || state == sfcar_pkg::ST_DUMMY)) begin
            next_in_sh = byte_in;
            next_bit_cnt = bit_cnt + 3'h1;
        end
        if (cs_n_s) begin
            // select high aborts and tristates output
            next_state = sfcar_pkg::ST_IDLE;
            next_so_oe_n = 1'b1;
            next_bit_cnt = sfcar_pkg::BIT_FIRST;
        end else begin
            unique case (state)
                sfcar_pkg::ST_IDLE: begin
                    // fresh select assertion starts a command
                    // counters restart so no state leaks from the last frame
                    next_state = sfcar_pkg::ST_OPCODE;
                    next_bit_cnt = sfcar_pkg::BIT_FIRST;
                    next_addr_cnt = 2'h0;
                    next_out_cnt = sfcar_pkg::BIT_FIRST;
                end
                sfcar_pkg::ST_OPCODE: begin
                    if (byte_done) begin
                        next_state = sfcar_pkg::ST_ADDR;
                        unique case (byte_in)
                            sfcar_pkg::OP_READ_FASTEST: next_dummy_left = sfcar_pkg::DUMMY_FASTEST;
                            // high rate read owes one dummy
                            sfcar_pkg::OP_READ_HIGH: next_dummy_left = sfcar_pkg::DUMMY_HIGH;
                            sfcar_pkg::OP_READ_LOW: next_dummy_left = sfcar_pkg::DUMMY_NONE;
                            sfcar_pkg::OP_READ_LOW_POWER: next_dummy_left = sfcar_pkg::DUMMY_NONE;
                            // other opcodes are not served here
                            default: next_state = sfcar_pkg::ST_IGNORE;
                        endcase
                    end
                end
                sfcar_pkg::ST_ADDR: begin
                    if (byte_done) begin
                        next_addr_cnt = addr_cnt + 2'h1;
                        next_addr_sh = {addr_sh[7:0], byte_in};
                        if (addr_cnt == sfcar_pkg::ADDR_BYTE_LAST) begin
                            // three bytes form the start address
                            next_rd_addr = map_addr({addr_sh, byte_in}, page_256_i);
                            if (dummy_left == sfcar_pkg::DUMMY_NONE) begin
                                next_state = sfcar_pkg::ST_DATA;
                            end else begin
                                next_state = sfcar_pkg::ST_DUMMY;
                            end
                        end
                    end
                end
                sfcar_pkg::ST_DUMMY: begin
                    // dummy contents are discarded
                    if (byte_done) begin
                        next_dummy_left = dummy_left - 2'h1;
                        // data follows the last owed dummy byte
                        if (dummy_left == sfcar_pkg::DUMMY_ONE) begin
                            next_state = sfcar_pkg::ST_DATA;
                        end
                    end
                end
                sfcar_pkg::ST_DATA: begin
                    // every falling clock shifts one bit out
                    if (sck_fall) begin
                        next_so_oe_n = 1'b0;
                        next_out_cnt = out_cnt + 3'h1;
                        // the array byte must already stand at the input here:
                        // the external port has several clocks after each step
                        if (out_cnt == sfcar_pkg::BIT_FIRST) begin
                            next_so = array_data_i[7];
                            next_out_sh = {array_data_i[6:0], 1'b0};
                            // counter steps as the byte is taken
                            next_rd_addr = next_addr(rd_addr, page_256_i);
                        end else begin
                            next_so = out_sh[7];
                            next_out_sh = {out_sh[6:0], 1'b0};
                        end
                    end
                end
                sfcar_pkg::ST_IGNORE: begin
                    // wait for select to rise
                    // unserved opcodes keep the output released
                    next_so_oe_n = 1'b1;
                end
            endcase
        end
    end

    // register the sequencer; the reset values leave the pin released
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= sfcar_pkg::ST_IDLE;
            bit_cnt <= 3'h0;
            in_sh <= 8'h00;
            addr_cnt <= 2'h0;
            dummy_left <= 2'h0;
            addr_sh <= 16'h0000;
            rd_addr <= '0;
            out_sh <= 8'h00;
            out_cnt <= 3'h0;
            so <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            in_sh <= next_in_sh;
            addr_cnt <= next_addr_cnt;
            dummy_left <= next_dummy_left;
            addr_sh <= next_addr_sh;
            rd_addr <= next_rd_addr;
            out_sh <= next_out_sh;
            out_cnt <= next_out_cnt;
            so <= next_so;
            so_oe_n <= next_so_oe_n;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    // so_o, so_oe_n_o and array_addr_o come straight from flip-flops, but
    // active_o is decoded from the state register and can glitch
    // array address only, no buffer write path exists
    assign array_addr_o = rd_addr;
    assign so_o = so;
    assign so_oe_n_o = so_oe_n;
    assign active_o = (state == sfcar_pkg::ST_DATA);

endmodule : sfcar_read

/* rtl/sfcar_placeholder_none.sv */
// (intentionally empty of logic: none)

/* verification/sfcar_read_props.sv */
// port checks of the continuous read sequencer
`timescale 1ns/1ns
module sfcar_read_props (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic page_256_i,
    input wire logic [7:0] array_data_i,
    input wire logic so_o,
    input wire logic so_oe_n_o,
    input wire sfcar_pkg::sfcar_array_addr_s array_addr_o,
    input wire logic active_o
);
    // ****
    // helper: where the counter goes next
    // ****
    logic [8:0] ofs_last; // last byte of a page
    sfcar_pkg::sfcar_array_addr_s nxt_addr; // expected next address
    always_comb begin
        ofs_last = page_256_i ? 9'h0ff : 9'h107;
        nxt_addr = array_addr_o;
        // page end moves to byte zero of the next page
        if (array_addr_o.byte_offset_bits == ofs_last) begin
            nxt_addr = {array_addr_o.page_index_bits + 12'h001, 9'h000};
        end else begin
            nxt_addr.byte_offset_bits = array_addr_o.byte_offset_bits + 9'h001;
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // ****
    // assertions
    // ****
    AST_RESET_QUIET: assert property ($fell(rst_i) |-> so_oe_n_o && !active_o
        && array_addr_o == 21'h00000) else $error("outputs not idle after reset");
    AST_ABORT_TRISTATE: assert property ($rose(cs_n_i) |-> ##[2:6] (so_oe_n_o && !active_o))
        else $error("output still driven after select rose");
    AST_IDLE_NO_DRIVE: assert property (cs_n_i [*6] |-> so_oe_n_o && !active_o)
        else $error("output driven while deselected");
    AST_FIRST_DRIVE: assert property ($fell(so_oe_n_o) |-> active_o && !cs_n_i)
        else $error("drive started outside data phase");
    AST_WAIT_FALL: assert property ($rose(active_o) |-> so_oe_n_o [*2])
        else $error("drive started before a clock fall");
    AST_SELECT_HELD: assert property ($rose(active_o) |-> !cs_n_i && !$past(cs_n_i, 4))
        else $error("data phase without held select");
    AST_SO_STEADY: assert property ($rose(sck_i) ##2 1'b1 |-> $stable(so_o) [*3])
        else $error("data out moved while clock high");
    AST_ADDR_RANGE: assert property (active_o |-> array_addr_o.byte_offset_bits <= ofs_last)
        else $error("byte offset beyond page");
    AST_ADDR_STEP: assert property (active_o && $past(active_o) && $changed(array_addr_o)
        |-> array_addr_o == $past(nxt_addr)) else $error("address counter misstep");
endmodule : sfcar_read_props
bind sfcar_read sfcar_read_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
    .sck_i(sck_i), .si_i(si_i), .page_256_i(page_256_i), .array_data_i(array_data_i),
    .so_o(so_o), .so_oe_n_o(so_oe_n_o), .array_addr_o(array_addr_o), .active_o(active_o));

/* verification/sfcar_host.sv */
// serial host model: select, clock and input out, data gathered back
`timescale 1ns/1ns
module sfcar_host (
    input wire logic clk_sys_i,
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    logic [7:0] rx_q[$]; // whole bytes read back
    initial begin
        cs_n_o = 1'h1;
        sck_o = 1'h0;
        si_o = 1'h0;
    end
    // one frame, mode 0, clock idle low between frames
    task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int ndum,
        input int nbits);
        logic [31:0] hdr;
        logic [7:0] acc;
        int hb;
        hdr = {op, adr};
        hb = 32 + 8 * ndum;
        rx_q = {};
        acc = 8'h00;
        @(posedge clk_sys_i);
        cs_n_o <= 1'h0;
        repeat (4) @(posedge clk_sys_i);
        // select held, one slow rate, msb first
        for (int i = 0; i < hb + nbits; i++) begin
            sck_o <= 1'h0;
            si_o <= (i < 32) ? hdr[31 - i] : ~si_o;
            repeat (4) @(posedge clk_sys_i);
            sck_o <= 1'h1;
            repeat (4) @(posedge clk_sys_i);
            // sample late in the high phase, partial byte dropped
            if (i >= hb) begin
                acc = {acc[6:0], so_i};
                if ((i - hb) % 8 == 7) rx_q.push_back(acc);
            end
        end
        sck_o <= 1'h0;
        repeat (4) @(posedge clk_sys_i);
        cs_n_o <= 1'h1;
        si_o <= ~si_o;
        repeat (6) @(posedge clk_sys_i);
    endtask : frame
endmodule : sfcar_host

/* verification/sfcar_read_tb_top.sv */
// self-checking bench of the continuous read sequencer
`timescale 1ns/1ns
module sfcar_read_tb_top;
    // ****
    // signals and instances
    // ****
    logic clk_sys, rst, cs_n, sck, si, page_256, so, so_oe_n, so_line, active;
    logic [7:0] array_data; // array model output
    sfcar_pkg::sfcar_array_addr_s array_addr;
    logic [31:0] lfsr; // random source
    int n_mismatch = 0;
    int num_checks = 0;
    int n_drive = 0; // cycles with output driven
    logic [7:0] ops [4] = '{8'h1b, 8'h0b, 8'h03, 8'h01};
    int dum [4] = '{2, 1, 0, 0};
    logic [23:0] corners [4] = '{24'he00b06, 24'h0012fe, 24'h1fff07, 24'h0fffff};
    sfcar_read dut (.clk_sys_i(clk_sys), .rst_i(rst), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .page_256_i(page_256), .array_data_i(array_data), .so_o(so), .so_oe_n_o(so_oe_n),
        .array_addr_o(array_addr), .active_o(active));
    // released line shows the inverse of its last level
    assign so_line = so_oe_n ? ~so : so;
    sfcar_host host (.clk_sys_i(clk_sys), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end
    // array model and drive counter
    always @(posedge clk_sys) begin
        array_data <= byte_of(array_addr);
        if (so_oe_n === 1'h0) n_drive <= n_drive + 1;
    end
    // ****
    // expectation helpers
    // ****
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] byte_of(input logic [20:0] a);
        return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
    endfunction : byte_of
    function automatic logic [20:0] start_of(input logic [23:0] raw, input logic p256);
        return p256 ? {raw[19:8], 1'h0, raw[7:0]} : raw[20:0];
    endfunction : start_of
    function automatic logic [20:0] step(input logic [20:0] a, input logic p256);
        if (a[8:0] == (p256 ? 9'h0ff : 9'h107)) return {a[20:9] + 12'h001, 9'h000};
        return {a[20:9], a[8:0] + 9'h001};
    endfunction : step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one read frame and its byte stream compared
    task automatic rd(input logic [7:0] op, input logic [23:0] raw, input int nd, input int nb);
        logic [20:0] a;
        a = start_of(raw, page_256);
        host.frame(op, raw, nd, nb * 8);
        chk(8'(host.rx_q.size()), 8'(nb));
        for (int k = 0; k < host.rx_q.size(); k++) begin
            chk(host.rx_q[k], byte_of(a));
            a = step(a, page_256);
        end
        chk({7'h0, so_oe_n}, 8'h01);
        $display("read %h at %h done", op, raw);
    endtask : rd
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        #2000000;
        n_mismatch++;
        $display("Error %0t: run timed out", $time);
        final_report();
    end
    // ****
    // main sequence
    // ****
    initial begin
        int base;
        logic [23:0] raw; // random start address
        rst = 1'h1;
        page_256 = 1'h0;
        lfsr = 32'h1b;
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (4) @(posedge clk_sys);
        // every opcode, both layouts, random start
        for (int i = 0; i < 8; i++) begin
            repeat (8) lfsr = lfsr_next(lfsr);
            page_256 <= lfsr[0];
            @(posedge clk_sys);
            raw = lfsr[31:8];
            // 264 layout: keep the start byte inside the page
            if (!lfsr[0] && raw[8:0] > 9'h107) begin
                raw[8] = 1'b0;
            end
            rd(ops[i % 4], raw, dum[i % 4], 2);
        end
        // page ends, array end, ignored top bits
        for (int i = 0; i < 4; i++) begin
            page_256 <= i[0];
            @(posedge clk_sys);
            rd(8'h0b, corners[i], 1, 3);
        end
        // select rises mid byte, then a clean read
        host.frame(8'h03, 24'h000123, 0, 13);
        chk(8'(host.rx_q.size()), 8'h01);
        chk(host.rx_q[0], byte_of(start_of(24'h000123, page_256)));
        rd(8'h01, 24'h000200, 0, 2);
        // unknown opcode never drives the output
        base = n_drive;
        host.frame(8'h9f, 24'h000000, 0, 16);
        chk(8'(n_drive - base), 8'h00);
        $display("abort and refusal done");
        final_report();
    end
endmodule : sfcar_read_tb_top
